// >>> hdl/tsc_top.sv
// Command and control core of a serial digital thermostat.
// Assumes the sensor word inputs come from logic on the system clock and
// that the serial clock pin is also the link clock and a convert input.
`timescale 1ns/1ps
module tsc_top import tsc_pkg::*; #(
	parameter int CONV_CYC = CONV_CYCLES,
	parameter int NVWR_CYC = NVWR_CYCLES
) (
	// System clock and reset
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	// Three-wire port
	input wire logic SERIAL_CLOCK_CONVERT_PIN_I,
	input wire logic XFER_SEL_I,
	input wire logic DQ_I,
	output logic DQ_O,
	output logic DQ_OE_O,
	// Sensor front end
	input wire logic [8:0] TEMP_I,
	input wire logic [8:0] COUNT_I,
	input wire logic [8:0] SLOPE_I,
	output logic SENSE_RUN_O,
	// Thermostat outputs
	output logic OVER_LIMIT_O,
	output logic UNDER_LIMIT_O,
	output logic HYSTERESIS_O
);
	// Elaboration checks on the long counts
	generate
		if (CONV_CYC < 2 || CONV_CYC >= (1 << CNT_W))
			$error("conversion count out of range");
		if (NVWR_CYC < 2 || NVWR_CYC >= (1 << CNT_W))
			$error("nonvolatile write count out of range");
	endgenerate

	typedef struct packed {
		logic sel_d;
		logic pin_d;
		logic host_sel;
		logic single;
		logic high_flag;
		logic low_flag;
		logic busy;
		logic run;
		logic [CNT_W-1:0] conv_cnt;
		logic [CNT_W-1:0] nv_cnt;
		logic [8:0] upper;
		logic [8:0] lower;
		logic [8:0] temp;
		logic [8:0] count;
		logic [8:0] slope;
		logic over;
		logic under;
		logic hyst;
		tsc_snap_type snap;
	} tsc_state_type;

	tsc_state_type s, next_s;
	tsc_cmd_type cmd;
	logic [1:0] pins_s;
	logic sel_s;
	logic pin_s;
	logic link_dq;
	logic link_oe;
	logic stand_alone;
	logic frame_end;
	logic [7:0] cfg;
	logic start;

	// Serial port on the link clock
	tsc_link u_link (
		.sclk_i(SERIAL_CLOCK_CONVERT_PIN_I),
		.sel_i(XFER_SEL_I),
		.dq_i(DQ_I),
		.dq_o(link_dq),
		.dq_oe_o(link_oe),
		.snap_i(s.snap),
		.cmd_o(cmd)
	);

	// Frame select and clock pin brought into the system domain
	tsc_sync #(.W(2)) u_sync (
		.clk_i(MCLK_I),
		.d_i({XFER_SEL_I, SERIAL_CLOCK_CONVERT_PIN_I}),
		.q_o(pins_s)
	);

	assign sel_s = pins_s[1];
	assign pin_s = pins_s[0];

	// Status byte as the host sees it
	always_comb begin
		cfg = 8'h00;
		cfg[CFG_DONE] = ~s.busy;
		cfg[CFG_HIGH] = s.high_flag;
		cfg[CFG_LOW] = s.low_flag;
		cfg[CFG_BUSY] = s.nv_cnt != '0;
		cfg[CFG_ONE] = 1'b1;
		cfg[CFG_ZERO] = 1'b0;
		cfg[CFG_HOST] = s.host_sel;
		cfg[CFG_SINGLE] = s.single;
	end

	// Pin acts as convert input only with host select 0 and frame closed
	assign stand_alone = ~s.host_sel & ~sel_s;
	// Command record is quiet once the frame has closed
	assign frame_end = s.sel_d & ~sel_s & cmd.ok;

	// Sequencer, limits, flags and outputs
	always_comb begin
		next_s = s;
		start = 1'b0;
		next_s.sel_d = sel_s;
		next_s.pin_d = pin_s;
		if (s.nv_cnt != '0)
			next_s.nv_cnt = s.nv_cnt - 1'b1;

		// Commands taken when the frame closes
		if (frame_end) begin
			case (cmd.op)
				OP_START: begin
					next_s.run = ~s.single;
					start = 1'b1;
				end
				OP_STOP: begin
					next_s.run = 1'b0;
				end
				OP_WR_UPPER: begin
					next_s.upper = cmd.data;
					next_s.nv_cnt = CNT_W'(NVWR_CYC);
				end
				OP_WR_LOWER: begin
					next_s.lower = cmd.data;
					next_s.nv_cnt = CNT_W'(NVWR_CYC);
				end
				OP_WR_CFG: begin
					next_s.high_flag = s.high_flag & cmd.data[CFG_HIGH];
					next_s.low_flag = s.low_flag & cmd.data[CFG_LOW];
					next_s.host_sel = cmd.data[CFG_HOST];
					next_s.single = cmd.data[CFG_SINGLE];
					next_s.nv_cnt = CNT_W'(NVWR_CYC);
				end
				default: begin
					next_s.run = s.run;
				end
			endcase
		end

		// Falling edge of the convert pin starts a conversion
		if (stand_alone && s.pin_d && !pin_s)
			start = 1'b1;

		// Conversion timer and end-of-conversion updates
		if (s.busy) begin
			next_s.conv_cnt = s.conv_cnt - 1'b1;
			if (s.conv_cnt == CNT_W'(1)) begin
				next_s.temp = TEMP_I;
				next_s.count = COUNT_I;
				next_s.slope = SLOPE_I;
				// Set wins over a clear in the same cycle
				if ($signed(TEMP_I) >= $signed(s.upper))
					next_s.high_flag = 1'b1;
				if ($signed(TEMP_I) <= $signed(s.lower))
					next_s.low_flag = 1'b1;
				next_s.over = $signed(TEMP_I) >= $signed(s.upper);
				next_s.under = $signed(TEMP_I) <= $signed(s.lower);
				if ($signed(TEMP_I) >= $signed(s.upper))
					next_s.hyst = 1'b1;
				else if ($signed(TEMP_I) <= $signed(s.lower))
					next_s.hyst = 1'b0;
				// Keep going while continuous or the pin is held low
				if (next_s.run || (stand_alone && !pin_s))
					next_s.conv_cnt = CNT_W'(CONV_CYC);
				else
					next_s.busy = 1'b0;
			end
		end else if (start) begin
			next_s.busy = 1'b1;
			next_s.conv_cnt = CNT_W'(CONV_CYC);
		end

		// Readable words refresh only while no frame is open
		if (!sel_s) begin
			next_s.snap.temp = s.temp;
			next_s.snap.count = s.count;
			next_s.snap.slope = s.slope;
			next_s.snap.upper = s.upper;
			next_s.snap.lower = s.lower;
			next_s.snap.cfg = cfg;
		end
	end

	// State register with synchronous reset
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			s <= '0;
			s.sel_d <= 1'b0;
			s.pin_d <= 1'b1;
			s.upper <= RST_UPPER;
			s.lower <= RST_LOWER;
			s.temp <= RST_TEMP;
			s.snap.upper <= RST_UPPER;
			s.snap.lower <= RST_LOWER;
			s.snap.temp <= RST_TEMP;
			s.snap.cfg <= 8'h88;
		end else begin
			s <= next_s;
		end
	end

	// Outputs
	assign SENSE_RUN_O = s.busy;
	assign OVER_LIMIT_O = s.over;
	assign UNDER_LIMIT_O = s.under;
	assign HYSTERESIS_O = s.hyst;
	assign DQ_O = link_dq;
	assign DQ_OE_O = link_oe;
endmodule

// >>> hdl/tsc_pkg.sv
// Shared constants and carrier types of the thermostat serial command block.
// Assumes a 20 MHz system clock; long counts are overridable at the top level.
package tsc_pkg;

	// System clock and documented times
	localparam int MCLK_HZ = 20_000_000;
	localparam int T_CONV_MS = 750;
	localparam int T_NVWR_MS = 10;
	localparam int CONV_CYCLES = T_CONV_MS * (MCLK_HZ / 1000);
	localparam int NVWR_CYCLES = T_NVWR_MS * (MCLK_HZ / 1000);
	localparam int CNT_W = 24;

	// Opcodes, received least significant bit first
	localparam logic [7:0] OP_RD_TEMP = 8'haa;
	localparam logic [7:0] OP_RD_COUNT = 8'ha0;
	localparam logic [7:0] OP_RD_SLOPE = 8'ha9;
	localparam logic [7:0] OP_WR_UPPER = 8'h01;
	localparam logic [7:0] OP_WR_LOWER = 8'h02;
	localparam logic [7:0] OP_RD_UPPER = 8'ha1;
	localparam logic [7:0] OP_RD_LOWER = 8'ha2;
	localparam logic [7:0] OP_START = 8'hee;
	localparam logic [7:0] OP_STOP = 8'h22;
	localparam logic [7:0] OP_WR_CFG = 8'h0c;
	localparam logic [7:0] OP_RD_CFG = 8'hac;

	// Frame layout in serial clock cycles
	localparam logic [4:0] OPC_BITS = 5'h08;
	localparam logic [4:0] WORD_BITS = 5'h09;
	localparam logic [4:0] CFG_BITS = 5'h08;
	localparam logic [4:0] CNT_MAX = 5'h1f;

	// Configuration/status byte field positions
	localparam int CFG_DONE = 7;
	localparam int CFG_HIGH = 6;
	localparam int CFG_LOW = 5;
	localparam int CFG_BUSY = 4;
	localparam int CFG_ONE = 3;
	localparam int CFG_ZERO = 2;
	localparam int CFG_HOST = 1;
	localparam int CFG_SINGLE = 0;

	// Reset values of the nonvolatile limits and the result word
	localparam logic [8:0] RST_UPPER = 9'h01e;
	localparam logic [8:0] RST_LOWER = 9'h014;
	localparam logic [8:0] RST_TEMP = 9'h188;

	// Readable words frozen for the link while a frame is open
	typedef struct packed {
		logic [8:0] temp;
		logic [8:0] count;
		logic [8:0] slope;
		logic [8:0] upper;
		logic [8:0] lower;
		logic [7:0] cfg;
	} tsc_snap_type;

	// Completed command handed from the link to the system side
	typedef struct packed {
		logic ok;
		logic [7:0] op;
		logic [8:0] data;
	} tsc_cmd_type;

endpackage

// >>> hdl/tsc_sync.sv
// Two-flop level synchroniser into the system clock domain.
// Assumes the input is a level that may change at any time.
`timescale 1ns/1ps
module tsc_sync import tsc_pkg::*; #(
	parameter int W = 1
) (
	// Clock and level
	input wire logic clk_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta;
	logic [W-1:0] stable;

	// First stage feeds only the second
	always_ff @(posedge clk_i) begin
		meta <= d_i;
		stable <= meta;
	end

	assign q_o = stable;
endmodule

// >>> hdl/tsc_link.sv
// Serial port shifter on the link clock: opcode in, data in or out.
// Assumes the frame-select level is steady around link clock edges.
`timescale 1ns/1ps
module tsc_link import tsc_pkg::*; (
	// Link pins
	input wire logic sclk_i,
	input wire logic sel_i,
	input wire logic dq_i,
	output logic dq_o,
	output logic dq_oe_o,
	// Exchange with the system side
	input wire tsc_snap_type snap_i,
	output tsc_cmd_type cmd_o
);
	typedef struct packed {
		logic [4:0] cnt;
		logic [7:0] op;
		logic [8:0] dat;
	} tsc_rise_type;

	typedef struct packed {
		logic drive;
		logic bit_out;
	} tsc_fall_type;

	tsc_rise_type r, next_r;
	tsc_fall_type f, next_f;
	tsc_cmd_type c, next_c;
	logic [4:0] idx;
	logic [13:0] rword;

	// Word and length of a read opcode; length zero marks no read
	function automatic logic [13:0] read_word(input logic [7:0] op, input tsc_snap_type s);
		case (op)
			OP_RD_TEMP: read_word = {WORD_BITS, s.temp};
			OP_RD_COUNT: read_word = {WORD_BITS, s.count};
			OP_RD_SLOPE: read_word = {WORD_BITS, s.slope};
			OP_RD_UPPER: read_word = {WORD_BITS, s.upper};
			OP_RD_LOWER: read_word = {WORD_BITS, s.lower};
			OP_RD_CFG: read_word = {CFG_BITS, 1'b0, s.cfg};
			default: read_word = 14'h0000;
		endcase
	endfunction

	// Rising edge: sample opcode then data, least significant bit first
	always_comb begin
		next_r = r;
		next_c = c;
		if (r.cnt != CNT_MAX)
			next_r.cnt = r.cnt + 5'h01;
		if (r.cnt < OPC_BITS)
			next_r.op = {dq_i, r.op[7:1]};
		else
			next_r.dat = {dq_i, r.dat[8:1]};
		if (r.cnt == 5'h00)
			next_c.ok = 1'b0;
		// Data-less commands complete with the opcode
		if (r.cnt == OPC_BITS - 5'h01 && ({dq_i, r.op[7:1]} == OP_START || {dq_i, r.op[7:1]} == OP_STOP)) begin
			next_c = '{ok: 1'b1, op: {dq_i, r.op[7:1]}, data: 9'h000};
		end
		// Nine-bit writes complete on the ninth data bit; later bits ignored
		if (r.cnt == OPC_BITS + WORD_BITS - 5'h01 && (r.op == OP_WR_UPPER || r.op == OP_WR_LOWER))
			next_c = '{ok: 1'b1, op: r.op, data: {dq_i, r.dat[8:1]}};
		if (r.cnt == OPC_BITS + CFG_BITS - 5'h01 && r.op == OP_WR_CFG)
			next_c = '{ok: 1'b1, op: r.op, data: {1'b0, dq_i, r.dat[8:2]}};
	end

	// Frame state cleared while select is low: abort
	always_ff @(posedge sclk_i or negedge sel_i) begin
		if (!sel_i)
			r <= '0;
		else
			r <= next_r;
	end

	// Command record kept after the frame for the system side
	always_ff @(posedge sclk_i) begin
		if (sel_i)
			c <= next_c;
	end

	// Falling edge: present the next read bit, zeros past the top bit
	always_comb begin
		idx = r.cnt - OPC_BITS;
		rword = read_word(r.op, snap_i);
		next_f = '0;
		if (r.cnt >= OPC_BITS && rword[13:9] != 5'h00) begin
			next_f.drive = 1'b1;
			if (idx < rword[13:9])
				next_f.bit_out = rword[idx[3:0]];
		end
	end

	always_ff @(negedge sclk_i or negedge sel_i) begin
		if (!sel_i)
			f <= '0;
		else
			f <= next_f;
	end

	// Released whenever the clock is high or the frame is closed
	assign dq_o = f.bit_out;
	assign dq_oe_o = f.drive & ~sclk_i & sel_i;
	assign cmd_o = c;
endmodule

// >>> test/tsc_asserts.sv
// Concurrent checks on the ports of the thermostat serial command core.
// Assumes the trip limits are kept with the upper one above the lower one.
`timescale 1ns/1ps
module tsc_asserts import tsc_pkg::*; #(
	parameter int CONV_CYC = CONV_CYCLES,
	parameter int NVWR_CYC = NVWR_CYCLES
) (
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	// Watched signals
	input wire logic SERIAL_CLOCK_CONVERT_PIN_I,
	input wire logic XFER_SEL_I,
	input wire logic DQ_OE_O,
	input wire logic SENSE_RUN_O,
	input wire logic OVER_LIMIT_O,
	input wire logic UNDER_LIMIT_O,
	input wire logic HYSTERESIS_O
);
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);

	// Data line drive and release
	oe_clk_low_a: assert property (DQ_OE_O |-> !SERIAL_CLOCK_CONVERT_PIN_I)
		else $error("data driven while clock high");
	oe_sel_a: assert property (!XFER_SEL_I |-> !DQ_OE_O)
		else $error("data driven outside a frame");
	// Thermostat outputs
	over_hyst_a: assert property (OVER_LIMIT_O |-> HYSTERESIS_O)
		else $error("over limit without hysteresis");
	under_hyst_a: assert property (UNDER_LIMIT_O |-> !HYSTERESIS_O)
		else $error("under limit with hysteresis");
	hyst_rise_a: assert property ($rose(HYSTERESIS_O) |-> OVER_LIMIT_O)
		else $error("hysteresis set below upper limit");
	over_under_a: assert property (!(OVER_LIMIT_O && UNDER_LIMIT_O))
		else $error("over and under limit together");
	// Conversion and reset
	run_len_a: assert property ($rose(SENSE_RUN_O) |-> SENSE_RUN_O [*8])
		else $error("conversion ended early");
	rst_out_a: assert property ($rose(RST_N_I) |-> !(SENSE_RUN_O || OVER_LIMIT_O || HYSTERESIS_O))
		else $error("outputs not cleared by reset");

	// Main scenarios
	run_c: cover property ($rose(SENSE_RUN_O));
	drive_c: cover property (DQ_OE_O);
	hyst_c: cover property ($rose(HYSTERESIS_O));
	under_c: cover property ($rose(UNDER_LIMIT_O));
endmodule

bind tsc_top tsc_asserts #(.CONV_CYC(CONV_CYC), .NVWR_CYC(NVWR_CYC)) u_chk (
	.MCLK_I(MCLK_I),
	.RST_N_I(RST_N_I),
	.SERIAL_CLOCK_CONVERT_PIN_I(SERIAL_CLOCK_CONVERT_PIN_I),
	.XFER_SEL_I(XFER_SEL_I),
	.DQ_OE_O(DQ_OE_O),
	.SENSE_RUN_O(SENSE_RUN_O),
	.OVER_LIMIT_O(OVER_LIMIT_O),
	.UNDER_LIMIT_O(UNDER_LIMIT_O),
	.HYSTERESIS_O(HYSTERESIS_O)
);

// >>> test/tsc_host.sv
// Host model on the three-wire port: frames, 15 ns link clock, convert pulses.
// Assumes the bench resolves the data line, pulled up when nobody drives it.
`timescale 1ns/1ps
module tsc_host (
	// Port pins
	output logic sclk_o,
	output logic sel_o,
	output logic dq_o,
	output logic dq_oe_o,
	input wire logic dq_line_i
);
	// Idle: clock high and still, frame closed, data released
	initial begin
		sclk_o = 1'b1;
		sel_o = 1'b1;
		dq_o = 1'b0;
		dq_oe_o = 1'b0;
		// A closing select edge clears the link frame state before any frame
		#1 sel_o = 1'b0;
	end

	// One frame: opcode then nd data bits, written or read
	task automatic xfer(input logic [7:0] op, input int nd, input logic rd,
		input logic [15:0] wd, output logic [15:0] rv);
		logic [23:0] bits;
		bits = {wd, op};
		rv = '0;
		// Off the system clock edge, so the link clock stays out of phase
		#3 sel_o = 1'b1;
		#200;
		for (int i = 0; i < 8 + nd; i++) begin
			sclk_o = 1'b0;
			dq_oe_o = (i < 8) || !rd;
			dq_o = bits[i];
			#7;
			if (i >= 8) rv[i-8] = dq_line_i;
			#0.5 sclk_o = 1'b1;
			#7.5;
		end
		dq_oe_o = 1'b0;
		#10 sel_o = 1'b0;
		#250;
	endtask

	// Convert pin held low for ns outside frames
	task automatic pin_low(input int ns);
		#3 sclk_o = 1'b0;
		#ns;
		sclk_o = 1'b1;
	endtask
endmodule

// >>> test/test_thermostat_serial_command_control.sv
// Self-checking bench of the thermostat core through its serial port.
// Assumes short conversion and write counts set by parameters below.
`timescale 1ns/1ps
module test_thermostat_serial_command_control import tsc_pkg::*; ;
	logic mclk = 1'b0;
	logic rst_n, sclk, sel, hdq, hoe, ddq, doe, run, over, under, hyst;
	logic [8:0] temp, count, slope;
	logic [15:0] v, outs;
	int errors = 0;
	int tests_run = 0;
	int run_total = 0;
	int t0, n_cyc = 0;

	// Clock and resolved data line with pull-up
	always #25 mclk = ~mclk;
	wire logic line = doe ? ddq : (hoe ? hdq : 1'b1);
	assign outs = {13'h0000, over, under, hyst};

	tsc_top #(.CONV_CYC(20), .NVWR_CYC(40)) u_dut (
		.MCLK_I(mclk), .RST_N_I(rst_n), .SERIAL_CLOCK_CONVERT_PIN_I(sclk),
		.XFER_SEL_I(sel), .DQ_I(line), .DQ_O(ddq), .DQ_OE_O(doe),
		.TEMP_I(temp), .COUNT_I(count), .SLOPE_I(slope), .SENSE_RUN_O(run),
		.OVER_LIMIT_O(over), .UNDER_LIMIT_O(under), .HYSTERESIS_O(hyst));
	tsc_host u_host (.sclk_o(sclk), .sel_o(sel), .dq_o(hdq), .dq_oe_o(hoe), .dq_line_i(line));

	// Conversion cycle tally and hang guard
	always @(posedge mclk) begin
		if (run === 1'b1) run_total++;
		n_cyc++;
		if (n_cyc == 20000) begin
			errors++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] op, input int nd, input logic [15:0] exp);
		logic [15:0] r;
		u_host.xfer(op, nd, 1'b1, 16'h0000, r);
		chk(r, exp);
	endtask
	task automatic wr(input logic [7:0] op, input int nd, input logic [15:0] d);
		logic [15:0] r;
		u_host.xfer(op, nd, 1'b0, d, r);
		cyc(60);
	endtask
	task automatic ran(input int lo, input int hi);
		chk(16'(run_total - t0 >= lo && run_total - t0 <= hi), 16'h0001);
	endtask

	// Main sequence
	initial begin
		rst_n = 1'b0;
		{temp, count, slope} = '0;
		cyc(3);
		rst_n <= 1'b1;
		cyc(5);
		rd(OP_RD_CFG, 8, 16'h0088);
		rd(OP_RD_UPPER, 16, 16'h001e);
		rd(OP_RD_LOWER, 9, 16'h0014);
		rd(OP_RD_TEMP, 9, 16'h0188);
		u_host.xfer(OP_WR_UPPER, 9, 1'b0, 16'h0050, v);
		rd(OP_RD_CFG, 8, 16'h0098);
		cyc(60);
		rd(OP_RD_CFG, 8, 16'h0088);
		wr(OP_WR_LOWER, 16, 16'hfe20);
		u_host.xfer(OP_WR_UPPER, 5, 1'b0, 16'h001f, v);
		u_host.xfer(OP_RD_TEMP, 4, 1'b1, 16'h0000, v);
		chk(v, 16'h0008);
		cyc(60);
		rd(OP_RD_UPPER, 9, 16'h0050);
		rd(OP_RD_LOWER, 9, 16'h0020);
		wr(OP_WR_CFG, 8, 16'h0007);
		rd(OP_RD_CFG, 8, 16'h008b);
		// One conversion above the upper limit
		@(posedge mclk);
		temp <= 9'h060;
		count <= 9'h0a5;
		slope <= 9'h05a;
		t0 = run_total;
		u_host.xfer(OP_START, 0, 1'b0, 16'h0000, v);
		cyc(100);
		ran(20, 20);
		chk(outs, 16'h0005);
		rd(OP_RD_TEMP, 9, 16'h0060);
		rd(OP_RD_COUNT, 9, 16'h00a5);
		rd(OP_RD_SLOPE, 9, 16'h005a);
		rd(OP_RD_CFG, 8, 16'h00cb);
		// Result between the limits: hysteresis holds, high flag stays
		@(posedge mclk);
		temp <= 9'h030;
		t0 = run_total;
		u_host.xfer(OP_START, 0, 1'b0, 16'h0000, v);
		cyc(100);
		ran(20, 20);
		chk(outs, 16'h0001);
		rd(OP_RD_TEMP, 9, 16'h0030);
		rd(OP_RD_CFG, 8, 16'h00cb);
		@(posedge mclk);
		temp <= 9'h000;
		t0 = run_total;
		u_host.pin_low(100);
		cyc(60);
		ran(0, 0);
		chk(outs, 16'h0001);
		// Stand-alone start below the lower limit
		wr(OP_WR_CFG, 8, 16'h0000);
		rd(OP_RD_CFG, 8, 16'h0088);
		t0 = run_total;
		u_host.pin_low(100);
		cyc(100);
		ran(20, 20);
		chk(outs, 16'h0002);
		rd(OP_RD_CFG, 8, 16'h00a8);
		// Continuous run, then stop
		t0 = run_total;
		u_host.xfer(OP_START, 0, 1'b0, 16'h0000, v);
		cyc(80);
		u_host.xfer(OP_STOP, 0, 1'b0, 16'h0000, v);
		cyc(60);
		ran(91, 125);
		t0 = run_total;
		cyc(40);
		ran(0, 0);
		// Pin held low overrides single mode
		wr(OP_WR_CFG, 8, 16'h0001);
		t0 = run_total;
		u_host.pin_low(5000);
		cyc(60);
		ran(86, 125);
		t0 = run_total;
		cyc(40);
		ran(0, 0);
		// Reset while idle returns outputs and status byte to defaults
		@(posedge mclk);
		rst_n <= 1'b0;
		cyc(3);
		rst_n <= 1'b1;
		cyc(5);
		chk(outs, 16'h0000);
		rd(OP_RD_CFG, 8, 16'h0088);
		end_sim();
	end
endmodule
